/* shared/adb_pkg.sv */
/*
 * Constants shared by the converter board control block: register offsets,
 * field positions, reset values and the conversion timing.
 * Assumes a 100 MHz system clock and 8-bit host registers on four select bits.
 */
package adb_pkg;

	////////////////////////////////////////////////////////////////////////////
	localparam logic [3:0] OFS_ADC_LOW = 4'h0;
	localparam logic [3:0] OFS_ADC_HIGH = 4'h1;
	localparam logic [3:0] OFS_MODE_STATUS = 4'h2;
	localparam logic [3:0] OFS_DIO = 4'h3;
	localparam logic [3:0] OFS_DAC_LOW = 4'h6;
	localparam logic [3:0] OFS_DAC_HIGH_RESET = 4'h7;

	////////////////////////////////////////////////////////////////////////////
	localparam int MODE_CLEAR_BIT = 3;
	localparam int MODE_EDGE_BIT = 6;
	localparam int MODE_ENABLE_BIT = 7;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_FLAG_BIT = 3;
	localparam int STAT_PIN_BIT = 6;

	////////////////////////////////////////////////////////////////////////////
	localparam logic [2:0] CHAN_RESET = 3'h0;
	localparam logic [11:0] DAC_CODE_RESET = 12'h800;
	localparam logic [7:0] DAC_LOW_RESET = 8'h00;
	localparam logic [3:0] DOUT_RESET = 4'h0;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;
	localparam logic [7:0] STATUS_RESET = 8'h00;

	////////////////////////////////////////////////////////////////////////////
	localparam int CLK_PERIOD_NS = 10;
	localparam int CONV_TIME_NS = 10000;
	localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

/* hw/adb_conv_timer.sv */
/*
 * Conversion timer: holds the busy indication for a fixed conversion time
 * after each accepted start and pulses done when the result is ready.
 * Assumes a single clock; abort comes from the board soft reset.
 */
`timescale 1ns/100ps

module adb_conv_timer #(
	parameter int CONV_CYCLES = adb_pkg::CONV_CYCLES
) (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic start_in,
	input wire logic abort_in,
	output logic busy_out,
	output logic done_out
);

	localparam int CW = $clog2(CONV_CYCLES + 1);

	typedef struct packed {
		logic busy;
		logic done;
		logic [CW-1:0] count;
	} adb_tmr_s;

	adb_tmr_s st_reg;
	adb_tmr_s st_next;

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		st_next = st_reg;
		st_next.done = 1'b0;
		if (abort_in) begin
			st_next.busy = 1'b0;
			st_next.count = '0;
		end else if (st_reg.busy) begin
			if (st_reg.count == CW'(CONV_CYCLES - 1)) begin
				st_next.busy = 1'b0;
				st_next.done = 1'b1;
				st_next.count = '0;
			end else begin
				st_next.count = st_reg.count + 1'b1;
			end
		end else if (start_in) begin
			// Busy covers the whole converter time after the start.
			st_next.busy = 1'b1;
			st_next.count = '0;
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign busy_out = st_reg.busy;
	assign done_out = st_reg.done;

endmodule

/* hw/adb_board_ctrl.sv */
/*
 * Control logic of an add-on converter board reached over a host's
 * asynchronous external memory bus: 8-channel A/D start and result, 12-bit
 * D/A code, 4-bit discrete I/O and an external interrupt with edge select.
 * Assumes all bus pins are synchronous to clk_in and strobes last at least
 * two clock cycles; the analog converter sits outside.
 * A strobe held low is taken once, so the host lets it rise for at least one
 * sampled cycle between accesses. A soft reset leaves the strobe trackers and
 * the interrupt pin history alone, so it cannot fake an access or an edge.
 */
`timescale 1ns/100ps

module adb_board_ctrl #(
	// Identification value is arbitrary.
	parameter logic [7:0] BOARD_ID = 8'hA5,
	parameter int CONV_CYCLES = adb_pkg::CONV_CYCLES
) (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic board_chip_enable_space_n_in,
	input wire logic [11:0] upper_host_addr_bits_in,
	input wire logic [3:0] register_select_bits_in,
	input wire logic read_strobe_n_in,
	input wire logic write_strobe_n_in,
	input wire logic [7:0] host_data_in,
	output logic [7:0] host_data_out,
	output logic host_data_oe_out,
	input wire logic [3:0] addr_switch_high_in,
	input wire logic [3:0] addr_switch_mid_in,
	input wire logic [3:0] addr_switch_low_in,
	output logic [2:0] adc_channel_out,
	output logic adc_convert_out,
	input wire logic [11:0] adc_data_in,
	output logic [11:0] dac_code_out,
	input wire logic dac_range_select_in,
	output logic dac_offset_binary_out,
	input wire logic [3:0] discrete_input_in,
	output logic [3:0] discrete_output_out,
	input wire logic output_polarity_select_in,
	input wire logic ext_irq_in,
	output logic host_irq_line_four_out
);

	typedef struct packed {
		logic rd_prev;
		logic wr_prev;
		logic rd_active;
		logic [7:0] rd_data;
		logic [2:0] adc_chan;
		logic adc_convert;
		logic [11:0] adc_result;
		logic [7:0] dac_low;
		logic [11:0] dac_code;
		logic dac_bipolar;
		logic [3:0] dout_latch;
		logic [3:0] dout_pin;
		logic edge_rising;
		logic irq_enable;
		logic irq_flag;
		logic irq_prev;
	} adb_state_s;

	localparam adb_state_s ST_RESET = '{
		rd_prev: 1'b1,
		wr_prev: 1'b1,
		rd_active: 1'b0,
		rd_data: adb_pkg::UNMAPPED_READ,
		adc_chan: adb_pkg::CHAN_RESET,
		adc_convert: 1'b0,
		adc_result: 12'h000,
		dac_low: adb_pkg::DAC_LOW_RESET,
		dac_code: adb_pkg::DAC_CODE_RESET,
		dac_bipolar: 1'b0,
		dout_latch: adb_pkg::DOUT_RESET,
		dout_pin: adb_pkg::DOUT_RESET,
		edge_rising: 1'b0,
		irq_enable: 1'b0,
		irq_flag: 1'b0,
		irq_prev: 1'b0
	};

	adb_state_s st_reg;
	adb_state_s st_next;

	logic selected;
	logic rd_start;
	logic wr_start;
	logic start_ok;
	logic soft_reset;
	logic irq_event;
	logic conv_busy;
	logic conv_done;
	logic [7:0] status_byte;
	logic [7:0] read_mux;

	////////////////////////////////////////////////////////////////////////////
	// Conversion timing lives in its own module so the busy window is one count.

	adb_conv_timer #(
		.CONV_CYCLES(CONV_CYCLES)
	) u_conv_timer (
		.clk_in(clk_in),
		.resetn_in(resetn_in),
		.start_in(start_ok),
		.abort_in(soft_reset),
		.busy_out(conv_busy),
		.done_out(conv_done)
	);

	////////////////////////////////////////////////////////////////////////////
	// Bus decode. An access is taken once, on the cycle its strobe is first seen
	// low, so a long host strobe cannot repeat a side effect.

	always_comb begin
		selected = !board_chip_enable_space_n_in
			&& (upper_host_addr_bits_in ==
			{addr_switch_high_in, addr_switch_mid_in, addr_switch_low_in});
		rd_start = selected && st_reg.rd_prev && !read_strobe_n_in;
		wr_start = selected && st_reg.wr_prev && !write_strobe_n_in;
		// A second start during a conversion is ignored so the multiplexer stays put.
		start_ok = wr_start && (register_select_bits_in == adb_pkg::OFS_ADC_LOW)
			&& !conv_busy;
		soft_reset = rd_start
			&& (register_select_bits_in == adb_pkg::OFS_DAC_HIGH_RESET);
		if (st_reg.edge_rising) begin
			irq_event = ext_irq_in && !st_reg.irq_prev;
		end else begin
			irq_event = !ext_irq_in && st_reg.irq_prev;
		end
		irq_event = irq_event && st_reg.irq_enable;
	end

	always_comb begin
		status_byte = adb_pkg::STATUS_RESET;
		status_byte[adb_pkg::STAT_BUSY_BIT] = conv_busy;
		status_byte[adb_pkg::STAT_FLAG_BIT] = st_reg.irq_flag;
		status_byte[adb_pkg::STAT_PIN_BIT] = ext_irq_in;
	end

	always_comb begin
		unique case (register_select_bits_in)
			adb_pkg::OFS_ADC_LOW: begin
				read_mux = st_reg.adc_result[7:0];
			end
			adb_pkg::OFS_ADC_HIGH: begin
				read_mux = {4'h0, st_reg.adc_result[11:8]};
			end
			adb_pkg::OFS_MODE_STATUS: begin
				read_mux = status_byte;
			end
			adb_pkg::OFS_DIO: begin
				read_mux = {4'h0, discrete_input_in};
			end
			adb_pkg::OFS_DAC_HIGH_RESET: begin
				read_mux = BOARD_ID;
			end
			default: begin
				read_mux = adb_pkg::UNMAPPED_READ;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Next state.

	always_comb begin
		st_next = st_reg;
		st_next.rd_prev = read_strobe_n_in;
		st_next.wr_prev = write_strobe_n_in;
		st_next.irq_prev = ext_irq_in;
		st_next.adc_convert = start_ok;

		// Read data is captured once and held while the strobe stays low.
		if (rd_start) begin
			st_next.rd_data = read_mux;
			st_next.rd_active = 1'b1;
		end else if (read_strobe_n_in || board_chip_enable_space_n_in) begin
			st_next.rd_active = 1'b0;
		end

		if (start_ok) begin
			st_next.adc_chan = host_data_in[2:0];
		end
		if (conv_done) begin
			// The converter hands over offset binary; it is stored unchanged.
			st_next.adc_result = adc_data_in;
		end

		if (wr_start) begin
			unique case (register_select_bits_in)
				adb_pkg::OFS_MODE_STATUS: begin
					st_next.edge_rising = host_data_in[adb_pkg::MODE_EDGE_BIT];
					st_next.irq_enable = host_data_in[adb_pkg::MODE_ENABLE_BIT];
					if (host_data_in[adb_pkg::MODE_CLEAR_BIT]) begin
						st_next.irq_flag = 1'b0;
					end
				end
				adb_pkg::OFS_DIO: begin
					st_next.dout_latch = host_data_in[3:0];
				end
				adb_pkg::OFS_DAC_LOW: begin
					st_next.dac_low = host_data_in;
				end
				adb_pkg::OFS_DAC_HIGH_RESET: begin
					// Only the high write updates the converter, so low goes first.
					st_next.dac_code = {host_data_in[3:0], st_reg.dac_low};
				end
				default: begin
					// Start is handled above; other offsets ignore writes.
				end
			endcase
		end

		// An event in the clearing cycle still sets the flag.
		if (irq_event) begin
			st_next.irq_flag = 1'b1;
		end

		// Interpretation of the code follows the range switch.
		st_next.dac_bipolar = dac_range_select_in;
		if (output_polarity_select_in) begin
			st_next.dout_pin = st_next.dout_latch;
		end else begin
			st_next.dout_pin = ~st_next.dout_latch;
		end

		if (soft_reset) begin
			// All but the bus trackers, read data, range bit and pin history return to reset values.
			st_next.adc_chan = ST_RESET.adc_chan;
			st_next.adc_convert = ST_RESET.adc_convert;
			st_next.adc_result = ST_RESET.adc_result;
			st_next.dac_low = ST_RESET.dac_low;
			st_next.dac_code = ST_RESET.dac_code;
			st_next.dout_latch = ST_RESET.dout_latch;
			st_next.edge_rising = ST_RESET.edge_rising;
			st_next.irq_enable = ST_RESET.irq_enable;
			st_next.irq_flag = ST_RESET.irq_flag;
			if (output_polarity_select_in) begin
				st_next.dout_pin = ST_RESET.dout_latch;
			end else begin
				st_next.dout_pin = ~ST_RESET.dout_latch;
			end
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			st_reg <= ST_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs.

	assign host_data_out = st_reg.rd_data;
	assign host_data_oe_out = st_reg.rd_active;
	assign adc_channel_out = st_reg.adc_chan;
	assign adc_convert_out = st_reg.adc_convert;
	assign dac_code_out = st_reg.dac_code;
	assign dac_offset_binary_out = st_reg.dac_bipolar;
	assign discrete_output_out = st_reg.dout_pin;
	assign host_irq_line_four_out = st_reg.irq_flag;

endmodule

/* tb/adb_board_asserts.sv */
/* Port-level checks on the converter board control block.
   Assumes it is bound to the block top and sees only its ports. */
`timescale 1ns/100ps
module adb_board_asserts #(
	parameter int CONV_CYCLES = 8
) (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic board_chip_enable_space_n_in,
	input wire logic [11:0] upper_host_addr_bits_in,
	input wire logic [3:0] register_select_bits_in,
	input wire logic read_strobe_n_in,
	input wire logic [7:0] host_data_out,
	input wire logic host_data_oe_out,
	input wire logic [3:0] addr_switch_high_in,
	input wire logic [3:0] addr_switch_mid_in,
	input wire logic [3:0] addr_switch_low_in,
	input wire logic adc_convert_out,
	input wire logic [11:0] dac_code_out,
	input wire logic ext_irq_in,
	input wire logic host_irq_line_four_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	logic hit;
	assign hit = !board_chip_enable_space_n_in && upper_host_addr_bits_in ==
		{addr_switch_high_in, addr_switch_mid_in, addr_switch_low_in};
	////////////////////////////////////////////////////////////////
	AST_UNSEL_QUIET: assert property (
		board_chip_enable_space_n_in && $past(board_chip_enable_space_n_in) |-> !host_data_oe_out)
		else $error("drive while unselected");
	AST_READ_ANSWER: assert property (
		$fell(read_strobe_n_in) && hit |=> host_data_oe_out) else $error("read not answered");
	AST_IDLE_QUIET: assert property (
		read_strobe_n_in && $past(read_strobe_n_in) |-> !host_data_oe_out)
		else $error("drive without read");
	AST_CONV_SPACING: assert property (
		adc_convert_out |=> !adc_convert_out [*4]) else $error("start during conversion");
	AST_DAC_ON_HIGH: assert property (
		$changed(dac_code_out) |-> $past(register_select_bits_in) == 4'h7)
		else $error("code moved without high write");
	AST_IRQ_EDGE: assert property (
		$rose(host_irq_line_four_out) |-> $past(ext_irq_in) != $past(ext_irq_in, 2))
		else $error("flag without pin edge");
	AST_UNMAPPED_ZERO: assert property (
		host_data_oe_out && $stable(register_select_bits_in) && (register_select_bits_in[3] ||
		register_select_bits_in inside {4'h4, 4'h5, 4'h6}) |-> host_data_out == 8'h00)
		else $error("unmapped read not zero");
	AST_HIGH_PAD: assert property (
		host_data_oe_out && register_select_bits_in == 4'h1 |-> host_data_out[7:4] == 4'h0)
		else $error("result pad bits set");
	AST_STATUS_PAD: assert property (
		host_data_oe_out && register_select_bits_in == 4'h2 |->
		{host_data_out[7], host_data_out[5:4], host_data_out[2:1]} == 5'h00)
		else $error("status unused bits set");
	cover property ($rose(host_irq_line_four_out));
	cover property (adc_convert_out);
	cover property ($fell(read_strobe_n_in) && hit && register_select_bits_in == 4'h7);
endmodule
bind adb_board_ctrl adb_board_asserts #(.CONV_CYCLES(CONV_CYCLES)) u_asserts (.clk_in,
	.resetn_in, .board_chip_enable_space_n_in, .upper_host_addr_bits_in,
	.register_select_bits_in, .read_strobe_n_in, .host_data_out, .host_data_oe_out,
	.addr_switch_high_in, .addr_switch_mid_in, .addr_switch_low_in, .adc_convert_out,
	.dac_code_out, .ext_irq_in, .host_irq_line_four_out);

/* tb/adb_host_model.sv */
/* Host memory bus master model: one access at a time, strobes low two cycles.
   Assumes a single caller process; released write data shows its inverse. */
`timescale 1ns/100ps
module adb_host_model (
	input wire logic clk_in,
	output logic ce_n_out,
	output logic re_n_out,
	output logic we_n_out,
	output logic [3:0] sel_out,
	output logic [7:0] data_out
);
	initial begin
		ce_n_out = 1'b1;
		re_n_out = 1'b1;
		we_n_out = 1'b1;
		sel_out = 4'h0;
		data_out = 8'h00;
	end
	////////////////////////////////////////////////////////////////
	task automatic xfer(input logic wr, input logic [3:0] sel, input logic [7:0] d);
		@(posedge clk_in);
		ce_n_out <= 1'b0;
		sel_out <= sel;
		data_out <= d;
		re_n_out <= wr;
		we_n_out <= !wr;
		repeat (2) @(posedge clk_in);
		ce_n_out <= 1'b1;
		re_n_out <= 1'b1;
		we_n_out <= 1'b1;
		data_out <= ~d;
		repeat (2) @(posedge clk_in);
	endtask
endmodule

/* tb/test_adc_dac_dio_bus_port.sv */
/* Self-checking bench for the converter board control block.
   Assumes the host model and the bound checker are compiled with it. */
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_count++; \
	$display("[ERR] %0t got %h want %h", $time, a, b); end end
module test_adc_dac_dio_bus_port;
	localparam logic [7:0] ID = 8'h5C; // Arbitrary identification value.
	logic clk_in;
	logic resetn_in = 1'b0;
	logic board_chip_enable_space_n_in, read_strobe_n_in, write_strobe_n_in;
	logic [3:0] register_select_bits_in, discrete_output_out, discrete_input_in = 4'h0;
	logic [7:0] host_data_in, host_data_out, exp_v;
	logic [11:0] upper_host_addr_bits_in = 12'h5A3, adc_data_in = 12'h000, dac_code_out;
	logic host_data_oe_out, adc_convert_out, dac_offset_binary_out, host_irq_line_four_out;
	logic oe_d = 1'b0, dac_range_select_in = 1'b0, output_polarity_select_in = 1'b1;
	logic ext_irq_in = 1'b0;
	logic [2:0] adc_channel_out;
	logic [31:0] seed = 32'hEDE905C0, r;
	logic [7:0] q[$];
	int err_count = 0, total_checks = 0;
	int conv_count = 0;
	logic [11:0] switches = 12'h5A3;
	adb_board_ctrl #(.BOARD_ID(ID), .CONV_CYCLES(20)) dut (.clk_in, .resetn_in,
		.board_chip_enable_space_n_in, .upper_host_addr_bits_in, .register_select_bits_in,
		.read_strobe_n_in, .write_strobe_n_in, .host_data_in, .host_data_out,
		.host_data_oe_out, .addr_switch_high_in(switches[11:8]),
		.addr_switch_mid_in(switches[7:4]), .addr_switch_low_in(switches[3:0]),
		.adc_channel_out, .adc_convert_out, .adc_data_in,
		.dac_code_out, .dac_range_select_in, .dac_offset_binary_out, .discrete_input_in,
		.discrete_output_out, .output_polarity_select_in, .ext_irq_in, .host_irq_line_four_out);
	adb_host_model host (.clk_in, .ce_n_out(board_chip_enable_space_n_in),
		.re_n_out(read_strobe_n_in), .we_n_out(write_strobe_n_in),
		.sel_out(register_select_bits_in), .data_out(host_data_in));
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic wr(input logic [3:0] s, input logic [7:0] d);
		host.xfer(1'b1, s, d);
	endtask
	task automatic rd(input logic [3:0] s, input logic [7:0] e);
		q.push_back(e);
		host.xfer(1'b0, s, 8'h00);
	endtask
	task automatic final_report;
		if (q.size() != 0) err_count++;
		if (err_count == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	initial begin
		repeat (5000) @(posedge clk_in);
		err_count++;
		final_report;
	end
	// An answer with no note pending is a stray drive and counts as a mismatch.
	always @(posedge clk_in) begin
		oe_d <= host_data_oe_out;
		if (adc_convert_out === 1'b1) conv_count <= conv_count + 1;
		if (host_data_oe_out && !oe_d) begin
			exp_v = (q.size() != 0) ? q.pop_front() : ~host_data_out;
			`CHK(host_data_out, exp_v)
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge clk_in);
		resetn_in <= 1'b1;
		rd(4'h2, 8'h00);
		`CHK(dac_code_out, 12'h800)
		r = rnd();
		adc_data_in <= r[23:12];
		wr(4'h0, r[7:0]);
		`CHK(adc_channel_out, r[2:0])
		`CHK(conv_count, 1)
		rd(4'h2, 8'h01);
		wr(4'h0, ~r[7:0]);
		`CHK(adc_channel_out, r[2:0])
		`CHK(conv_count, 1)
		repeat (20) @(posedge clk_in);
		rd(4'h2, 8'h00);
		rd(4'h0, r[19:12]);
		rd(4'h1, {4'h0, r[23:20]});
		r = rnd();
		dac_range_select_in <= r[24];
		discrete_input_in <= r[19:16];
		wr(4'h6, r[7:0]);
		`CHK(dac_code_out, 12'h800)
		wr(4'h7, {r[15:12], r[11:8]});
		`CHK(dac_code_out, r[11:0])
		`CHK(dac_offset_binary_out, r[24])
		wr(4'h3, r[7:0]);
		`CHK(discrete_output_out, r[3:0])
		rd(4'h3, {4'h0, r[19:16]});
		output_polarity_select_in <= 1'b0;
		repeat (3) @(posedge clk_in);
		`CHK(discrete_output_out, ~r[3:0])
		output_polarity_select_in <= 1'b1;
		for (int s = 1; s < 16; s++) begin
			if (s inside {2, 3, 6, 7}) continue;
			wr(s[3:0], r[15:8]);
			rd(s[3:0], (s == 1) ? {4'h0, adc_data_in[11:8]} : 8'h00);
		end
		rd(4'h6, 8'h00);
		upper_host_addr_bits_in <= 12'hA5C;
		wr(4'h3, ~r[7:0]);
		upper_host_addr_bits_in <= 12'h5A3;
		switches <= 12'h5A2;
		host.xfer(1'b0, 4'h7, 8'h00);
		switches <= 12'h5A3;
		`CHK(discrete_output_out, r[3:0])
		`CHK(dac_code_out, r[11:0])
		for (int k = 0; k < 2; k++) begin
			ext_irq_in <= k[0];
			wr(4'h2, {1'b1, k[0], 6'h08});
			ext_irq_in <= !k[0];
			repeat (3) @(posedge clk_in);
			`CHK(host_irq_line_four_out, 1'b0)
			ext_irq_in <= k[0];
			repeat (3) @(posedge clk_in);
			`CHK(host_irq_line_four_out, 1'b1)
			rd(4'h2, {1'b0, k[0], 6'h08});
			wr(4'h2, {1'b1, k[0], 6'h00});
			`CHK(host_irq_line_four_out, 1'b1)
			wr(4'h2, 8'h08);
			`CHK(host_irq_line_four_out, 1'b0)
			ext_irq_in <= !k[0];
			repeat (3) @(posedge clk_in);
			ext_irq_in <= k[0];
			repeat (3) @(posedge clk_in);
			`CHK(host_irq_line_four_out, 1'b0)
		end
		wr(4'h3, 8'h0F);
		wr(4'h0, 8'h05);
		`CHK(conv_count, 2)
		rd(4'h7, ID);
		rd(4'h2, {1'b0, ext_irq_in, 6'h00});
		`CHK(dac_code_out, 12'h800)
		`CHK(adc_channel_out, 3'h0)
		`CHK(discrete_output_out, 4'h0)
		final_report;
	end
endmodule
